// >>> hdl/dccmd_engine.sv
// Behaviour
// - Command 0011cccc turns corrected output on for channel cccc; no parameter.
// - Command 0101cccc verifies constants; one parameter, bit 0 picks current or voltage.
// - After verification error_flag_n goes 0 on bad checksum, 1 on good.
// - Verification set chosen by parameter bit only, jumper ignored.
// - Command 10101010 loads raw zero code into every channel at once.
// - Command 11110000 then parameter 11110111 clears mains-loss and internal-fault conditions no longer present at the inputs.
// - Command 0100cccc takes seven bytes: offset hi, lo, gain msb..lsb, checksum.
// - Loaded constants go to voltage or current set by channel jumper.
// - Corrected code is offset plus code minus floor(gain times code over 2^32).
// - Gain is 32-bit unsigned, offset is signed two's complement.
// - Each channel output code resets to 8000 hex.
// - Command 0010cccc turns corrected output off for channel cccc; no parameter.
// - Command 0000xxxx sets error flag to 1 and drops any pending command.
// - Commands run only after all parameters; invalid command drives error flag 0.
// - Channel above 3 is ignored; error flag updated after its final parameter.
`timescale 1ns/100ps
module dccmd_engine
	import dccmd_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_byte,
	input wire logic parm_wr,
	input wire logic [7:0] parm_byte,
	input wire logic code_wr,
	input wire logic [1:0] code_ch,
	input wire logic [15:0] code_data,
	input wire logic [3:0] jumper_voltage,
	input wire logic mains_loss_in,
	input wire logic internal_fault_in_n,
	output logic error_flag_n,
	output logic mains_loss_condition,
	output logic internal_fault_n,
	output logic cmd_ready,
	output logic [3:0] cal_on,
	output logic [15:0] dac_code_0,
	output logic [15:0] dac_code_1,
	output logic [15:0] dac_code_2,
	output logic [15:0] dac_code_3
);
	import dccmd_pkg::*;

	// Constant storage, index {channel, voltage set}
	logic [15:0] offset_mem [0:2*NUM_CH-1];
	logic [31:0] gain_mem [0:2*NUM_CH-1];
	logic [7:0] sum_mem [0:2*NUM_CH-1];

	logic [1:0] jv_meta_reg [0:NUM_CH-1];
	logic [3:0] jumper_sync;
	logic [1:0] ml_meta_reg;
	logic [1:0] ie_meta_reg;

	dccmd_state_t state_reg, state_next;
	logic err_reg, err_next;
	logic ml_reg, ml_next;
	logic ie_reg, ie_next;
	logic [3:0] cal_reg, cal_next;
	logic [3:0] sel_reg, sel_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [7:0] acc_reg, acc_next;
	logic setv_reg, setv_next;
	logic [15:0] code_reg [0:NUM_CH-1];
	logic [15:0] code_next [0:NUM_CH-1];
	logic [1:0] corr_ch_reg, corr_ch_next;
	logic [15:0] corr_x_reg, corr_x_next;
	logic [55:0] load_reg, load_next;
	logic store_en;
	logic [2:0] store_idx;

	logic [2:0] corr_idx;
	logic [47:0] corr_prod;
	logic [15:0] corr_val;
	logic [2:0] chk_idx;
	logic [7:0] chk_sum;
	logic check_pend_reg, check_pend_next;

	// Pin inputs pass two flip-flops
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < NUM_CH; i++)
				jv_meta_reg[i] <= 2'b00;
			ml_meta_reg <= 2'b00;
			ie_meta_reg <= 2'b11;
		end
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
				jv_meta_reg[i] <= {jv_meta_reg[i][0], jumper_voltage[i]};
			ml_meta_reg <= {ml_meta_reg[0], mains_loss_in};
			ie_meta_reg <= {ie_meta_reg[0], internal_fault_in_n};
		end
	end

	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
			jumper_sync[i] = jv_meta_reg[i][1];
	end

	// Verification sum over the chosen set
	always_comb
	begin
		chk_idx = {sel_reg[1:0], setv_reg};
		chk_sum = offset_mem[chk_idx][15:8] + offset_mem[chk_idx][7:0]
			+ gain_mem[chk_idx][31:24] + gain_mem[chk_idx][23:16]
			+ gain_mem[chk_idx][15:8] + gain_mem[chk_idx][7:0]
			+ sum_mem[chk_idx];
	end

	// Correction uses the set matching the channel jumper
	always_comb
	begin
		corr_idx = {corr_ch_reg, jumper_sync[corr_ch_reg]};
		corr_prod = 48'(gain_mem[corr_idx]) * 48'(corr_x_reg);
		corr_val = 16'(offset_mem[corr_idx] + corr_x_reg - corr_prod[47:32]);
	end

	always_comb
	begin
		state_next = state_reg;
		err_next = err_reg;
		ml_next = ml_reg | ml_meta_reg[1];
		ie_next = ie_reg & ie_meta_reg[1];
		cal_next = cal_reg;
		sel_next = sel_reg;
		cnt_next = cnt_reg;
		acc_next = acc_reg;
		setv_next = setv_reg;
		corr_ch_next = corr_ch_reg;
		corr_x_next = corr_x_reg;
		load_next = load_reg;
		store_en = 1'b0;
		store_idx = {sel_reg[1:0], jumper_sync[sel_reg[1:0]]};
		for (int i = 0; i < NUM_CH; i++)
			code_next[i] = code_reg[i];
		case (state_reg)
			DCCMD_IDLE:
			begin
				// Strobes are refused while the verification result is latched
				if (check_pend_reg)
					err_next = (chk_sum == 8'h00);
				else if (cmd_wr)
				begin
					sel_next = cmd_byte[3:0];
					if (cmd_byte == CMD_ZERO_ALL)
					begin
						for (int i = 0; i < NUM_CH; i++)
							code_next[i] = CODE_ZERO;
					end
					else if (cmd_byte == CMD_RESTART)
						state_next = DCCMD_WAIT_RESTART;
					else if (cmd_byte[7:4] == OP_NULL)
						err_next = 1'b1;
					else if (cmd_byte[7:4] == OP_CAL_OFF)
					begin
						if (cmd_byte[3:2] == 2'b00)
							cal_next[cmd_byte[1:0]] = 1'b0;
					end
					else if (cmd_byte[7:4] == OP_CAL_ON)
					begin
						if (cmd_byte[3:2] == 2'b00)
							cal_next[cmd_byte[1:0]] = 1'b1;
					end
					else if (cmd_byte[7:4] == OP_CHECK)
						state_next = DCCMD_WAIT_CHECK;
					else if (cmd_byte[7:4] == OP_LOAD)
					begin
						cnt_next = 3'h0;
						acc_next = 8'h00;
						state_next = DCCMD_WAIT_LOAD;
					end
					else
						err_next = 1'b0;
				end
				else if (code_wr)
				begin
					if (cal_reg[code_ch])
					begin
						corr_ch_next = code_ch;
						corr_x_next = code_data;
						state_next = DCCMD_CORRECT;
					end
					else
						code_next[code_ch] = code_data;
				end
			end
			DCCMD_CORRECT:
			begin
				code_next[corr_ch_reg] = corr_val;
				state_next = DCCMD_IDLE;
			end
			DCCMD_WAIT_CHECK:
			begin
				if (cmd_wr && cmd_byte[7:4] == OP_NULL)
				begin
					err_next = 1'b1;
					state_next = DCCMD_IDLE;
				end
				else if (parm_wr)
				begin
					setv_next = parm_byte[CHECK_BIT];
					state_next = DCCMD_IDLE;
					if (sel_reg[3:2] != 2'b00)
						err_next = 1'b1;
				end
			end
			DCCMD_WAIT_RESTART:
			begin
				if (cmd_wr && cmd_byte[7:4] == OP_NULL)
				begin
					err_next = 1'b1;
					state_next = DCCMD_IDLE;
				end
				else if (parm_wr)
				begin
					state_next = DCCMD_IDLE;
					if (parm_byte == PARM_RESTART)
					begin
						// A condition still present at restart keeps its flag raised
						ml_next = ml_meta_reg[1];
						ie_next = ie_meta_reg[1];
					end
					else
						err_next = 1'b0;
				end
			end
			DCCMD_WAIT_LOAD:
			begin
				if (cmd_wr && cmd_byte[7:4] == OP_NULL)
				begin
					err_next = 1'b1;
					state_next = DCCMD_IDLE;
				end
				else if (parm_wr)
				begin
					load_next = {load_reg[47:0], parm_byte};
					acc_next = acc_reg + parm_byte;
					cnt_next = cnt_reg + 3'h1;
					if (cnt_reg == LOAD_BYTES - 3'h1)
					begin
						state_next = DCCMD_IDLE;
						if (sel_reg[3:2] != 2'b00)
							err_next = 1'b1;
						else
						begin
							store_en = 1'b1;
							err_next = (acc_next == 8'h00);
						end
					end
				end
			end
			default:
				state_next = DCCMD_IDLE;
		endcase
	end

	// Verification outcome is latched in the cycle after the parameter
	always_comb
	begin
		check_pend_next = (state_reg == DCCMD_WAIT_CHECK) && parm_wr
			&& !(cmd_wr && cmd_byte[7:4] == OP_NULL) && sel_reg[3:2] == 2'b00;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= DCCMD_IDLE;
			err_reg <= 1'b1;
			ml_reg <= 1'b0;
			ie_reg <= 1'b1;
			cal_reg <= 4'h0;
			sel_reg <= 4'h0;
			cnt_reg <= 3'h0;
			acc_reg <= 8'h00;
			setv_reg <= 1'b0;
			corr_ch_reg <= 2'b00;
			corr_x_reg <= CODE_ZERO;
			load_reg <= 56'h0;
			check_pend_reg <= 1'b0;
			for (int i = 0; i < NUM_CH; i++)
				code_reg[i] <= CODE_ZERO;
		end
		else
		begin
			state_reg <= state_next;
			err_reg <= err_next;
			ml_reg <= ml_next;
			ie_reg <= ie_next;
			cal_reg <= cal_next;
			sel_reg <= sel_next;
			cnt_reg <= cnt_next;
			acc_reg <= acc_next;
			setv_reg <= setv_next;
			corr_ch_reg <= corr_ch_next;
			corr_x_reg <= corr_x_next;
			load_reg <= load_next;
			check_pend_reg <= check_pend_next;
			for (int i = 0; i < NUM_CH; i++)
				code_reg[i] <= code_next[i];
		end
	end

	// No reset on constant storage so it is kept across reset
	always_ff @(posedge core_clk)
	begin
		if (store_en)
		begin
			offset_mem[store_idx] <= load_reg[47:32];
			gain_mem[store_idx] <= load_reg[31:0];
			sum_mem[store_idx] <= parm_byte;
		end
	end

	assign error_flag_n = err_reg;
	assign mains_loss_condition = ml_reg;
	assign internal_fault_n = ie_reg;
	assign cmd_ready = (state_reg != DCCMD_CORRECT) && !check_pend_reg;
	assign cal_on = cal_reg;
	assign dac_code_0 = code_reg[0];
	assign dac_code_1 = code_reg[1];
	assign dac_code_2 = code_reg[2];
	assign dac_code_3 = code_reg[3];
endmodule

// >>> hdl/dccmd_pkg.sv
package dccmd_pkg;
	localparam int NUM_CH = 4;
	localparam int CH_W = 2;
	localparam logic [3:0] OP_NULL = 4'h0;
	localparam logic [3:0] OP_CAL_OFF = 4'h2;
	localparam logic [3:0] OP_CAL_ON = 4'h3;
	localparam logic [3:0] OP_LOAD = 4'h4;
	localparam logic [3:0] OP_CHECK = 4'h5;
	localparam logic [7:0] CMD_ZERO_ALL = 8'haa;
	localparam logic [7:0] CMD_RESTART = 8'hf0;
	localparam logic [7:0] PARM_RESTART = 8'hf7;
	localparam logic [2:0] LOAD_BYTES = 3'h7;
	localparam logic [15:0] CODE_ZERO = 16'h8000;
	localparam logic [15:0] OFFSET_RST = 16'h0000;
	localparam logic [31:0] GAIN_RST = 32'h00000000;
	localparam logic [7:0] SUM_RST = 8'h00;
	localparam int CHECK_BIT = 0;
	typedef enum logic [2:0] {DCCMD_IDLE, DCCMD_WAIT_CHECK, DCCMD_WAIT_RESTART,
		DCCMD_WAIT_LOAD, DCCMD_CORRECT} dccmd_state_t;
endpackage

// >>> tb/dccmd_checker.sv
`timescale 1ns/100ps
module dccmd_checker
	import dccmd_pkg::*;
(
	input logic core_clk,
	input logic resetn,
	input logic cmd_wr,
	input logic [7:0] cmd_byte,
	input logic parm_wr,
	input logic [7:0] parm_byte,
	input logic code_wr,
	input logic [1:0] code_ch,
	input logic [15:0] code_data,
	input logic mains_loss_in,
	input logic internal_fault_in_n,
	input logic error_flag_n,
	input logic mains_loss_condition,
	input logic internal_fault_n,
	input logic cmd_ready,
	input logic [3:0] cal_on,
	input logic [15:0] dac_code_0,
	input logic [15:0] dac_code_3
);
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic [7:0] op_reg;
	logic [7:0] op_next;
	logic take;
	logic bad_op;
	assign take = cmd_wr && cmd_ready && cnt_reg == 3'h0;
	assign bad_op = !(cmd_byte[7:4] inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h5})
		&& cmd_byte != CMD_ZERO_ALL && cmd_byte != CMD_RESTART;
	// Parameter bytes still owed to the pending command
	always_comb
	begin
		cnt_next = cnt_reg;
		op_next = op_reg;
		if (cmd_wr && cmd_ready && (cnt_reg == 3'h0 || cmd_byte[7:4] == OP_NULL))
		begin
			op_next = cmd_byte;
			cnt_next = (cmd_byte[7:4] == OP_LOAD) ? 3'h7 : 3'h0;
			if (cmd_byte[7:4] == OP_CHECK || cmd_byte == CMD_RESTART)
				cnt_next = 3'h1;
		end
		else if (parm_wr && cmd_ready && cnt_reg != 3'h0)
			cnt_next = cnt_reg - 3'h1;
	end
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			cnt_reg <= 3'h0;
			op_reg <= 8'h00;
		end
		else
		begin
			cnt_reg <= cnt_next;
			op_reg <= op_next;
		end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_clean;
		(!mains_loss_in && internal_fault_in_n) [*4];
	endsequence
	sequence s_restart;
		parm_wr && cmd_ready && cnt_reg == 3'h1 && op_reg == CMD_RESTART && parm_byte == PARM_RESTART;
	endsequence
	a_cal_on_set: assert property
		(take && cmd_byte[7:2] == 6'b001100 |=> cal_on[$past(cmd_byte[1:0])])
		else $error("cal on not set");
	a_cal_off_clr: assert property
		(take && cmd_byte[7:2] == 6'b001000 |=> !cal_on[$past(cmd_byte[1:0])])
		else $error("cal off not applied");
	a_far_chan: assert property
		(take && cmd_byte[7:5] == 3'b001 && cmd_byte[3:2] != 2'b00 |=> $stable(cal_on))
		else $error("far channel changed mode");
	a_zero_all: assert property
		(take && cmd_byte == CMD_ZERO_ALL |=> dac_code_0 == CODE_ZERO && dac_code_3 == CODE_ZERO)
		else $error("zero all missed");
	a_null_clr: assert property
		(cmd_wr && cmd_ready && cmd_byte[7:4] == OP_NULL |=> error_flag_n)
		else $error("null left error");
	a_bad_cmd: assert property
		(take && bad_op |=> !error_flag_n)
		else $error("invalid command not flagged");
	a_reset_out: assert property
		($rose(resetn) |-> dac_code_0 == CODE_ZERO && dac_code_3 == CODE_ZERO && cal_on == 4'h0)
		else $error("reset outputs wrong");
	a_raw_write: assert property
		(code_wr && cmd_ready && code_ch == 2'h0 && !cal_on[0] |=> dac_code_0 == $past(code_data))
		else $error("raw code not written");
	a_restart_clr: assert property
		(s_clean ##0 s_restart |=> !mains_loss_condition && internal_fault_n)
		else $error("restart did not recover");
endmodule
bind dccmd_engine dccmd_checker chk_i (.core_clk, .resetn, .cmd_wr, .cmd_byte, .parm_wr,
	.parm_byte, .code_wr, .code_ch, .code_data, .mains_loss_in, .internal_fault_in_n,
	.error_flag_n, .mains_loss_condition, .internal_fault_n, .cmd_ready, .cal_on,
	.dac_code_0, .dac_code_3);

// >>> tb/tb_dac_cal_command_engine.sv
`timescale 1ns/100ps
module tb_dac_cal_command_engine;
	import dccmd_pkg::*;
	logic core_clk, resetn, cmd_wr, parm_wr, code_wr, mains_loss_in, internal_fault_in_n;
	logic error_flag_n, mains_loss_condition, internal_fault_n, cmd_ready;
	logic [7:0] cmd_byte, parm_byte;
	logic [1:0] code_ch, c;
	logic [15:0] code_data, dac_code_0, dac_code_1, dac_code_2, dac_code_3, off, x;
	logic [15:0] codes [4];
	logic [3:0] jumper_voltage, cal_on;
	logic [31:0] gain;
	int bad_count, comparisons;
	assign codes = '{dac_code_0, dac_code_1, dac_code_2, dac_code_3};
	dccmd_engine DUT (.core_clk, .resetn, .cmd_wr, .cmd_byte, .parm_wr, .parm_byte, .code_wr,
		.code_ch, .code_data, .jumper_voltage, .mains_loss_in, .internal_fault_in_n,
		.error_flag_n, .mains_loss_condition, .internal_fault_n, .cmd_ready, .cal_on,
		.dac_code_0, .dac_code_1, .dac_code_2, .dac_code_3);
	initial
	begin
		core_clk = 0;
		forever #12.5 core_clk = ~core_clk;
	end
	task test_done;
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask
	task idle;
		int n;
		n = 0;
		#1;
		while (cmd_ready !== 1'b1)
		begin
			if (++n > 50)
			begin
				bad_count++;
				test_done();
			end
			@(posedge core_clk);
			#1;
		end
	endtask
	task go(input int k, input logic [15:0] d, input logic [1:0] ch = 2'h0);
		idle();
		@(posedge core_clk);
		cmd_wr <= k == 0;
		parm_wr <= k == 1;
		code_wr <= k == 2;
		cmd_byte <= d[7:0];
		parm_byte <= d[7:0];
		code_data <= d;
		code_ch <= ch;
		@(posedge core_clk);
		{cmd_wr, parm_wr, code_wr} <= 3'h0;
	endtask
	task settle;
		repeat (3) @(posedge core_clk);
		idle();
	endtask
	function logic [15:0] corr(input logic [15:0] o, input logic [31:0] k, input logic [15:0] v);
		logic [47:0] p;
		p = k * v;
		return o + v - p[47:32];
	endfunction
	// Seven bytes with a checksum that zeroes the byte sum, skewed on request
	task load(input logic [1:0] ch, input logic [15:0] o, input logic [31:0] k, input logic [7:0] sk);
		logic [7:0] b [7];
		b = '{o[15:8], o[7:0], k[31:24], k[23:16], k[15:8], k[7:0], sk};
		for (int i = 0; i < 6; i++)
			b[6] -= b[i];
		go(0, {12'h004, 2'h0, ch});
		foreach (b[i])
			go(1, {8'h00, b[i]});
	endtask
	initial
	begin
		{cmd_wr, parm_wr, code_wr, mains_loss_in, resetn} = 5'h0;
		{cmd_byte, parm_byte, code_ch, code_data} = '0;
		internal_fault_in_n = 1;
		jumper_voltage = 4'hf;
		x = 16'($urandom(54));
		repeat (4) @(posedge core_clk);
		resetn <= 1;
		idle();
		for (int i = 0; i < 4; i++)
			chk("reset code", 16'h8000, codes[i]);
		for (int i = 0; i < 6; i++)
		begin
			x = (i == 0) ? 16'hffff : 16'($urandom);
			c = (i == 0) ? 2'h0 : 2'($urandom);
			go(2, x, c);
			settle();
			chk("raw code", x, codes[c]);
		end
		load(3, 16'h0b7c, 32'h16f8f21a, 8'h00);
		settle();
		chk("good sum", 1, error_flag_n);
		off = 16'($urandom);
		gain = $urandom;
		@(posedge core_clk);
		jumper_voltage <= 4'h7;
		load(3, off, gain, 8'h01);
		settle();
		chk("bad sum", 0, error_flag_n);
		go(0, 16'h00);
		settle();
		chk("null", 1, error_flag_n);
		for (int m = 0; m < 2; m++)
		begin
			go(0, 16'h53);
			go(1, 16'(m));
			settle();
			chk("verify", m, error_flag_n);
		end
		@(posedge core_clk);
		jumper_voltage <= 4'hf;
		load(1, off, gain, 8'h00);
		go(0, 16'h31);
		go(0, 16'h33);
		settle();
		chk("cal on", 4'ha, cal_on);
		for (int i = 0; i < 4; i++)
		begin
			c = {i[0], 1'b1};
			x = (i < 2) ? 16'hffff : 16'($urandom);
			go(2, x, c);
			settle();
			chk("corrected", (c == 2'h3) ? corr(16'h0b7c, 32'h16f8f21a, x) : corr(off, gain, x),
				codes[c]);
		end
		go(0, 16'h37);
		settle();
		chk("far chan", 4'ha, cal_on);
		go(0, 16'h10);
		settle();
		chk("invalid", 0, error_flag_n);
		go(0, 16'h21);
		settle();
		chk("cal off", 4'h8, cal_on);
		@(posedge core_clk);
		mains_loss_in <= 1;
		internal_fault_in_n <= 0;
		repeat (4) @(posedge core_clk);
		mains_loss_in <= 0;
		internal_fault_in_n <= 1;
		repeat (4) @(posedge core_clk);
		chk("mains set", 1, mains_loss_condition);
		chk("fault set", 0, internal_fault_n);
		go(0, 16'hf0);
		go(1, 16'hf7);
		settle();
		chk("mains", 0, mains_loss_condition);
		chk("fault", 1, internal_fault_n);
		go(0, 16'haa);
		settle();
		for (int i = 0; i < 4; i++)
			chk("zero all", 16'h8000, codes[i]);
		@(posedge core_clk);
		resetn <= 0;
		@(posedge core_clk);
		resetn <= 1;
		go(0, 16'h33);
		x = 16'($urandom);
		go(2, x, 2'h3);
		settle();
		chk("kept", corr(16'h0b7c, 32'h16f8f21a, x), dac_code_3);
		test_done();
	end
endmodule
